// file: verilog/str_recorder.v
`include "str_defs.vh"
`default_nettype none
module str_recorder #(
    parameter [27:0] DEV_CYCLES = `STR_DEV_CYCLES,
    parameter [15:0] UNDR_CYCLES = `STR_UNDR_CYCLES
) (
    input wire clk_sys,
    input wire rst,
    input wire clk_en,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire tick_50us,
    input wire motion_active,
    input wire [7:0] dig_inputs,
    input wire [7:0] drive_outputs,
    input wire profile_stream_empty,
    input wire [1023:0] src_bus,
    input wire [15:0] inv_current,
    input wire [15:0] motor_speed,
    input wire [15:0] speed_change,
    input wire [31:0] motor_position,
    output reg motor_stop,
    output reg [4:0] fault_flags,
    output reg [1:0] rec_mode
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    reg [18:0] sync1_q;
    reg [18:0] sync2_q;
    wire tick_s = sync2_q[0];
    wire motion_s = sync2_q[1];
    wire [7:0] din_s = sync2_q[9:2];
    wire [7:0] dout_s = sync2_q[17:10];
    wire empty_s = sync2_q[18];

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sync1_q <= 19'h0_0000;
            sync2_q <= 19'h0_0000;
        end else if (clk_en) begin
            sync1_q <= {profile_stream_empty, drive_outputs, dig_inputs,
                        motion_active, tick_50us};
            sync2_q <= sync1_q;
        end
    end

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    function [31:0] src_pick;
        input [4:0] code;
        begin
            if ((code >= 5'h04 && code <= 5'h07) || code == 5'h0a)
                src_pick = 32'h0000_0000;
            else
                src_pick = src_bus[code * 32 +: 32];
        end
    endfunction

    function [15:0] abs16;
        input [15:0] v;
        begin
            abs16 = v[15] ? (~v + 16'h0001) : v;
        end
    endfunction

    // ------------------------------------------------------------
    // Registers and Avalon slave
    // ------------------------------------------------------------
    reg [19:0] src_sel_q;
    reg [3:0] trig_q;
    reg [15:0] rate_q;
    reg [31:0] level_q;
    reg [10:0] dump_q;
    reg [4:0] mask_q;
    reg [15:0] ovl_thr_q;
    reg [15:0] spd_thr_q;
    reg [15:0] dev_thr_q;
    reg [31:0] pos_hi_q;
    reg [31:0] pos_lo_q;
    reg [15:0] undr_thr_q;
    reg busy_q;
    reg ack_q;
    reg [15:0] rd0_q;
    reg [15:0] rd3_q;
    reg [9:0] cnt_q;
    reg [31:0] rd_d;
    wire [4:0] code1 = src_sel_q[4:0];
    wire wide1 = code1 < `STR_SRC_WIDE_LIMIT;
    wire req = avs_read | avs_write;
    wire wr_take = ack_q & avs_write;
    wire trig_wr = wr_take & (avs_address == `STR_REG_TRIG);
    wire mode_wr = wr_take & (avs_address == `STR_REG_MODE) &
                   (avs_writedata[1:0] == 2'b00);

    always @* begin
        rd_d = 32'h0000_0000;
        case (avs_address)
            `STR_REG_SRC_SEL: rd_d = {3'b000, src_sel_q[19:15], 3'b000,
                                      src_sel_q[14:10], 3'b000,
                                      src_sel_q[9:5], 3'b000, code1};
            `STR_REG_TRIG: rd_d = {28'h000_0000, trig_q};
            `STR_REG_RATE: rd_d = {16'h0000, rate_q};
            `STR_REG_LEVEL: rd_d = level_q;
            `STR_REG_MODE: rd_d = {6'h00, cnt_q, 14'h0000, rec_mode};
            `STR_REG_DUMP_PTR: rd_d = {21'h00_0000, dump_q};
            `STR_REG_DUMP_DATA: begin
                if (dump_q[10:9] == 2'b00 && wide1)
                    rd_d = {rd3_q, rd0_q};
                else
                    rd_d = {{16{rd0_q[15]}}, rd0_q};
            end
            `STR_REG_FLT: rd_d = {27'h000_0000, fault_flags};
            `STR_REG_FLT_MASK: rd_d = {27'h000_0000, mask_q};
            `STR_REG_OVL_THR: rd_d = {16'h0000, ovl_thr_q};
            `STR_REG_SPD_THR: rd_d = {16'h0000, spd_thr_q};
            `STR_REG_DEV_THR: rd_d = {16'h0000, dev_thr_q};
            `STR_REG_POS_HI: rd_d = pos_hi_q;
            `STR_REG_POS_LO: rd_d = pos_lo_q;
            `STR_REG_UNDR_THR: rd_d = {16'h0000, undr_thr_q};
            default: rd_d = 32'h0000_0000;
        endcase
    end

    // Each access is answered two cycles after it is seen, and a write
    // lands at the edge where the master sees waitrequest low.
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busy_q <= 1'b0;
            ack_q <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
            src_sel_q <= 20'h0_0000;
            trig_q <= 4'h0;
            rate_q <= `STR_RST_RATE;
            level_q <= 32'h0000_0000;
            dump_q <= 11'h000;
            mask_q <= 5'h00;
            ovl_thr_q <= `STR_RST_THR16;
            spd_thr_q <= `STR_RST_THR16;
            dev_thr_q <= `STR_RST_THR16;
            pos_hi_q <= `STR_RST_POS_HI;
            pos_lo_q <= `STR_RST_POS_LO;
            undr_thr_q <= `STR_RST_THR16;
        end else if (clk_en) begin
            busy_q <= req & ~busy_q & ~ack_q;
            ack_q <= busy_q;
            avs_waitrequest <= ~busy_q;
            if (busy_q)
                avs_readdata <= avs_read ? rd_d : 32'h0000_0000;
            if (ack_q && avs_read &&
                    avs_address == `STR_REG_DUMP_DATA) begin
                dump_q[8:0] <= dump_q[8:0] + 9'h001;
            end
            if (wr_take) begin
                case (avs_address)
                    `STR_REG_SRC_SEL: src_sel_q <= {avs_writedata[28:24],
                        avs_writedata[20:16], avs_writedata[12:8],
                        avs_writedata[4:0]};
                    `STR_REG_TRIG: trig_q <= avs_writedata[3:0];
                    `STR_REG_RATE: rate_q <= avs_writedata[15:0];
                    `STR_REG_LEVEL: level_q <= avs_writedata;
                    `STR_REG_DUMP_PTR: dump_q <= avs_writedata[10:0];
                    `STR_REG_FLT_MASK: mask_q <= avs_writedata[4:0];
                    `STR_REG_OVL_THR: ovl_thr_q <= avs_writedata[15:0];
                    `STR_REG_SPD_THR: spd_thr_q <= avs_writedata[15:0];
                    `STR_REG_DEV_THR: dev_thr_q <= avs_writedata[15:0];
                    `STR_REG_POS_HI: pos_hi_q <= avs_writedata;
                    `STR_REG_POS_LO: pos_lo_q <= avs_writedata;
                    `STR_REG_UNDR_THR: undr_thr_q <= avs_writedata[15:0];
                    default: ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // Sample store and channel values
    // ------------------------------------------------------------
    reg [15:0] sample_store [0:4*`STR_DEPTH-1];
    wire [63:0] ch_words;
    wire [31:0] ch1_full = src_pick(code1);
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_ch
            wire [31:0] v = src_pick(src_sel_q[gi*5 +: 5]);
            if (gi == 3) begin : g_hi
                assign ch_words[63:48] = wide1 ? ch1_full[31:16] :
                                         v[15:0];
            end else begin : g_lo
                assign ch_words[gi*16 +: 16] = v[15:0];
            end
        end
    endgenerate

    // Channel one as a signed 32-bit value for the level triggers.
    wire [31:0] cmp_val = wide1 ? ch1_full :
                          {{16{ch1_full[15]}}, ch1_full[15:0]};
    wire above = $signed(cmp_val) > $signed(level_q);
    wire below = $signed(cmp_val) < $signed(level_q);

    // ------------------------------------------------------------
    // Recorder state machine
    // ------------------------------------------------------------
    localparam [1:0] MD_IDLE = 2'b00;
    localparam [1:0] MD_ARMED = 2'b01;
    localparam [1:0] MD_FILL = 2'b10;
    localparam [1:0] MD_CIRC = 2'b11;

    reg tick_prev_q;
    reg motion_prev_q;
    reg [7:0] din_prev_q;
    reg [7:0] dout_prev_q;
    reg [15:0] rate_cnt_q;
    reg [8:0] wr_idx_q;
    reg [2:0] wseq_q;
    reg [63:0] cap_q;
    reg start_hit;
    reg stop_hit;
    wire tk = tick_s & ~tick_prev_q;
    wire mot_start = motion_s & ~motion_prev_q;
    wire mot_end = ~motion_s & motion_prev_q;
    wire in_chg = |((din_s ^ din_prev_q) & level_q[7:0]);
    wire out_chg = |(dout_s ^ dout_prev_q);
    wire recording = rec_mode == MD_FILL || rec_mode == MD_CIRC;
    wire [15:0] rate_eff = (rate_q == 16'h0000) ? 16'h0001 : rate_q;
    wire [1:0] wch = wseq_q[1:0] - 2'b01;

    always @* begin
        case (trig_q)
            4'h3: start_hit = mot_start;
            4'h7: start_hit = out_chg;
            4'h8: start_hit = in_chg;
            4'h9: start_hit = above;
            4'ha: start_hit = below;
            default: start_hit = 1'b0;
        endcase
        case (trig_q)
            4'h1: stop_hit = mot_end;
            4'h3: stop_hit = mot_end;
            4'h4: stop_hit = in_chg;
            4'h5: stop_hit = above;
            4'h6: stop_hit = below;
            default: stop_hit = 1'b0;
        endcase
    end

    always @(posedge clk_sys) begin
        if (clk_en) begin
            if (wseq_q != 3'b000)
                sample_store[{wch, wr_idx_q}] <= cap_q[wch*16 +: 16];
            rd0_q <= sample_store[dump_q];
            rd3_q <= sample_store[{2'b11, dump_q[8:0]}];
        end
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rec_mode <= MD_IDLE;
            tick_prev_q <= 1'b0;
            motion_prev_q <= 1'b0;
            din_prev_q <= 8'h00;
            dout_prev_q <= 8'h00;
            rate_cnt_q <= 16'h0000;
            wr_idx_q <= 9'h000;
            wseq_q <= 3'b000;
            cap_q <= 64'h0000_0000_0000_0000;
            cnt_q <= 10'h000;
        end else if (clk_en) begin
            tick_prev_q <= tick_s;
            if (tk) begin
                motion_prev_q <= motion_s;
                din_prev_q <= din_s;
                dout_prev_q <= dout_s;
            end
            // Four store writes follow each sample, one per cycle.
            if (wseq_q != 3'b000) begin
                if (wseq_q == 3'b100) begin
                    wseq_q <= 3'b000;
                    wr_idx_q <= wr_idx_q + 9'h001;
                    if (cnt_q != `STR_DEPTH)
                        cnt_q <= cnt_q + 10'h001;
                    if (rec_mode == MD_FILL && wr_idx_q == 9'h1ff)
                        rec_mode <= MD_IDLE;
                end else begin
                    wseq_q <= wseq_q + 3'b001;
                end
            end else if (tk && recording) begin
                if (rate_cnt_q == 16'h0000) begin
                    rate_cnt_q <= rate_eff - 16'h0001;
                    cap_q <= ch_words;
                    wseq_q <= 3'b001;
                end else begin
                    rate_cnt_q <= rate_cnt_q - 16'h0001;
                end
            end
            if (trig_wr) begin
                rate_cnt_q <= 16'h0000;
                wr_idx_q <= 9'h000;
                cnt_q <= 10'h000;
                wseq_q <= 3'b000;
                case (avs_writedata[3:0])
                    4'h1, 4'h4, 4'h5, 4'h6: rec_mode <= MD_CIRC;
                    4'h2: rec_mode <= MD_FILL;
                    4'h3, 4'h7, 4'h8, 4'h9, 4'ha:
                        rec_mode <= MD_ARMED;
                    default: rec_mode <= MD_IDLE;
                endcase
            end else if (mode_wr) begin
                rec_mode <= MD_IDLE;
            end else if (tk && rec_mode == MD_ARMED && start_hit) begin
                rec_mode <= (trig_q == 4'h3) ? MD_CIRC : MD_FILL;
                rate_cnt_q <= 16'h0000;
                wr_idx_q <= 9'h000;
                cnt_q <= 10'h000;
            end else if (tk && rec_mode == MD_CIRC && stop_hit) begin
                rec_mode <= MD_IDLE;
            end
        end
    end

    // ------------------------------------------------------------
    // Fault supervisor
    // ------------------------------------------------------------
    reg [27:0] dev_cnt_q;
    reg [15:0] undr_tmr_q;
    reg [15:0] undr_cnt_q;
    reg undr_flag_q;
    wire ovl_c = inv_current > ovl_thr_q;
    wire spd_c = abs16(motor_speed) > spd_thr_q;
    wire dev_c = abs16(speed_change) > dev_thr_q;
    wire pos_c = ($signed(motor_position) > $signed(pos_hi_q)) ||
                 ($signed(motor_position) < $signed(pos_lo_q));
    wire dev_flag = dev_cnt_q >= DEV_CYCLES;

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dev_cnt_q <= 28'h000_0000;
            undr_tmr_q <= 16'h0000;
            undr_cnt_q <= 16'h0000;
            undr_flag_q <= 1'b0;
            fault_flags <= 5'h00;
            motor_stop <= 1'b0;
        end else if (clk_en) begin
            if (!dev_c)
                dev_cnt_q <= 28'h000_0000;
            else if (!dev_flag)
                dev_cnt_q <= dev_cnt_q + 28'h000_0001;
            if (undr_tmr_q >= UNDR_CYCLES - 16'h0001) begin
                undr_tmr_q <= 16'h0000;
                if (empty_s) begin
                    if (undr_cnt_q != 16'hffff)
                        undr_cnt_q <= undr_cnt_q + 16'h0001;
                    undr_flag_q <= undr_cnt_q >= undr_thr_q;
                end else begin
                    undr_cnt_q <= 16'h0000;
                    undr_flag_q <= 1'b0;
                end
            end else begin
                undr_tmr_q <= undr_tmr_q + 16'h0001;
            end
            fault_flags <= {undr_flag_q, pos_c, dev_flag, spd_c,
                            ovl_c};
            motor_stop <= |(fault_flags & ~mask_q);
        end
    end
endmodule // str_recorder
`default_nettype wire

// file: verilog/str_defs.vh
`ifndef STR_DEFS_VH
`define STR_DEFS_VH
// ----------------------------------------------------------------
// Register word indices (byte address is four times the index)
// ----------------------------------------------------------------
`define STR_REG_SRC_SEL 4'h0
`define STR_REG_TRIG 4'h1
`define STR_REG_RATE 4'h2
`define STR_REG_LEVEL 4'h3
`define STR_REG_MODE 4'h4
`define STR_REG_DUMP_PTR 4'h5
`define STR_REG_DUMP_DATA 4'h6
`define STR_REG_FLT 4'h7
`define STR_REG_FLT_MASK 4'h8
`define STR_REG_OVL_THR 4'h9
`define STR_REG_SPD_THR 4'ha
`define STR_REG_DEV_THR 4'hb
`define STR_REG_POS_HI 4'hc
`define STR_REG_POS_LO 4'hd
`define STR_REG_UNDR_THR 4'he
// ----------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------
`define STR_FLT_OVL 0
`define STR_FLT_SPD 1
`define STR_FLT_DEV 2
`define STR_FLT_POS 3
`define STR_FLT_UNDR 4
`define STR_MODE_CNT_LSB 16
`define STR_RST_RATE 16'h0001
`define STR_RST_THR16 16'hffff
`define STR_RST_POS_HI 32'h7fff_ffff
`define STR_RST_POS_LO 32'h8000_0000
`define STR_SRC_WIDE_LIMIT 5'h08
// ----------------------------------------------------------------
// Buffer size and timing
// ----------------------------------------------------------------
`define STR_DEPTH 512
`define STR_CLK_NS 20
`define STR_DEV_TIME_S 5
`define STR_UNDR_TIME_US 1250
`define STR_DEV_CYCLES 28'hee6_b280
`define STR_UNDR_CYCLES 16'hf424
`endif

// file: dv/str_properties.sv
`default_nettype none
module str_properties #(
    parameter [27:0] DEV_CYCLES = 28'h000_0032,
    parameter [15:0] UNDR_CYCLES = 16'h0014
) (
    input wire clk_sys,
    input wire rst,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire avs_waitrequest,
    input wire profile_stream_empty,
    input wire [15:0] inv_current,
    input wire [15:0] motor_speed,
    input wire [15:0] speed_change,
    input wire [31:0] motor_position,
    input wire motor_stop,
    input wire [4:0] fault_flags,
    input wire [1:0] rec_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Helper counters and properties
    // ------------------------------------------------------------
    logic [27:0] dev_cnt_q;
    logic [19:0] full_cnt_q;
    function automatic logic [1:0] mode_query_cmd(input logic [3:0] t);
        case (t)
            4'h1, 4'h4, 4'h5, 4'h6: mode_query_cmd = 2'h3;
            4'h2: mode_query_cmd = 2'h2;
            4'h3, 4'h7, 4'h8, 4'h9, 4'ha: mode_query_cmd = 2'h1;
            default: mode_query_cmd = 2'h0;
        endcase
    endfunction
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dev_cnt_q <= 28'h000_0000;
            full_cnt_q <= 20'h0_0000;
        end else begin
            dev_cnt_q <= (speed_change != 16'h0000) ?
                dev_cnt_q + 28'h000_0001 : 28'h000_0000;
            full_cnt_q <= profile_stream_empty ?
                20'h0_0000 : full_cnt_q + 20'h0_0001;
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    AST_WAIT_ONE: assert property (
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    AST_ANSWER: assert property (
        $rose(avs_read || avs_write) |->
        avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus answer not at the fixed latency");
    AST_STOP: assert property (
        motor_stop |-> $past(fault_flags) != 5'h00)
        else $error("motor stop without a fault flag");
    AST_OVL: assert property (
        $past(inv_current) == 16'h0000 |-> !fault_flags[0])
        else $error("overload flag with zero current");
    AST_SPD: assert property (
        $past(motor_speed) == 16'h0000 |-> !fault_flags[1])
        else $error("overspeed flag with zero speed");
    AST_DEV: assert property (
        $rose(fault_flags[2]) |-> dev_cnt_q >= DEV_CYCLES - 28'h000_0001)
        else $error("deviation flag before the hold time");
    AST_POS: assert property (
        $past(motor_position) == 32'h0000_0000 |-> !fault_flags[3])
        else $error("position flag at position zero");
    AST_UNDR: assert property (
        full_cnt_q > UNDR_CYCLES + 16'h0008 |-> !fault_flags[4])
        else $error("underrun flag while the fifo holds data");
    AST_TRIG_MODE: assert property (
        avs_write && !avs_waitrequest && avs_address == 4'h1 |=>
        rec_mode == mode_query_cmd($past(avs_writedata[3:0])))
        else $error("recorder mode does not follow the trigger");
    COV_FILL: cover property (rec_mode == 2'h2);
    COV_DEV: cover property ($rose(fault_flags[2]));
    COV_STOP: cover property ($rose(motor_stop));
endmodule // str_properties
bind str_recorder str_properties #(
    .DEV_CYCLES(DEV_CYCLES),
    .UNDR_CYCLES(UNDR_CYCLES)
) u_props (
    .clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
    .profile_stream_empty(profile_stream_empty),
    .inv_current(inv_current), .motor_speed(motor_speed),
    .speed_change(speed_change), .motor_position(motor_position),
    .motor_stop(motor_stop), .fault_flags(fault_flags),
    .rec_mode(rec_mode)
);
`default_nettype wire

// file: dv/str_host_model.sv
`default_nettype none
module str_host_model (
    input wire logic clk_sys,
    output logic [3:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Host bus master holding each request until it is answered
    // ------------------------------------------------------------
    initial begin
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
    end
    // Source codes, triggers and levels all arrive through here.
    task automatic bus_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= v;
        avs_write <= 1'b1;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask
    // Dump entries are fetched one word per read.
    task automatic bus_rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk_sys);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        v = avs_readdata;
        avs_read <= 1'b0;
    endtask
endmodule // str_host_model
`default_nettype wire

// file: dv/str_recorder_bench.sv
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin \
    err_total++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
module str_recorder_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Stimulus, tasks and test sequence
    // ------------------------------------------------------------
    logic clk_sys, rst, tick_50us, motion_active, profile_stream_empty;
    logic [1023:0] src_bus;
    logic [15:0] inv_current, motor_speed, speed_change;
    logic [31:0] motor_position, d, e, avs_writedata, avs_readdata;
    logic [3:0] avs_address;
    logic avs_read, avs_write, avs_waitrequest, motor_stop;
    logic [4:0] fault_flags;
    logic [1:0] rec_mode;
    logic [7:0] dig_inputs, drive_outputs;
    int err_total = 0;
    int compares = 0;
    int n = 0;
    int n0;
    str_recorder #(.DEV_CYCLES(28'h000_0032), .UNDR_CYCLES(16'h0014)) u_dut (
        .clk_sys(clk_sys), .rst(rst), .clk_en(1'b1),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .tick_50us(tick_50us), .motion_active(motion_active),
        .dig_inputs(dig_inputs), .drive_outputs(drive_outputs),
        .profile_stream_empty(profile_stream_empty), .src_bus(src_bus),
        .inv_current(inv_current), .motor_speed(motor_speed),
        .speed_change(speed_change), .motor_position(motor_position),
        .motor_stop(motor_stop), .fault_flags(fault_flags),
        .rec_mode(rec_mode));
    str_host_model u_host (
        .clk_sys(clk_sys), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));
    function automatic logic [31:0] sv(input logic [4:0] c,
                                       input logic [7:0] t);
        sv = {3'h0, c, 8'h5a, t, 3'h0, c};
    endfunction
    function automatic logic [1:0] mode_query_cmd(input int t);
        case (t)
            1, 4, 5, 6: mode_query_cmd = 2'h3;
            2: mode_query_cmd = 2'h2;
            3, 7, 8, 9, 10: mode_query_cmd = 2'h1;
            default: mode_query_cmd = 2'h0;
        endcase
    endfunction
    task automatic tk(input int k);
        repeat (k) begin
            for (int c = 0; c < 32; c++) begin
                src_bus[c*32 +: 32] <= sv(c[4:0], n[7:0]);
            end
            tick_50us <= 1'b1;
            repeat (2) @(posedge clk_sys);
            tick_50us <= 1'b0;
            repeat (10) @(posedge clk_sys);
            n++;
        end
    endtask
    task automatic tally_and_finish;
        $display("errors %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (60000) @(posedge clk_sys);
        err_total++;
        $display("ERROR %0t run did not finish", $time);
        tally_and_finish();
    end
    initial begin
        {rst, tick_50us, motion_active, profile_stream_empty} = 4'h8;
        {inv_current, motor_speed, speed_change} = 48'h0;
        motor_position = 32'h0000_0000;
        {dig_inputs, drive_outputs} = 16'h0000;
        src_bus = '0;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        u_host.bus_rd(4'h2, d);
        `CHK(d, 32'h0000_0001);
        u_host.bus_rd(4'hb, d);
        `CHK(d, 32'h0000_ffff);
        u_host.bus_rd(4'hc, d);
        `CHK(d, 32'h7fff_ffff);
        u_host.bus_rd(4'hd, d);
        `CHK(d, 32'h8000_0000);
        u_host.bus_rd(4'he, d);
        `CHK(d, 32'h0000_ffff);
        u_host.bus_rd(4'hf, d);
        `CHK(d, 32'h0000_0000);
        u_host.bus_wr(4'h9, 32'h0000_0064);
        inv_current <= 16'h0065;
        repeat (4) @(posedge clk_sys);
        `CHK(motor_stop, 1'b1);
        u_host.bus_rd(4'h7, d);
        `CHK(d[4:0], 5'h01);
        u_host.bus_wr(4'h8, 32'h0000_0001);
        repeat (3) @(posedge clk_sys);
        `CHK(motor_stop, 1'b0);
        inv_current <= 16'h0064;
        repeat (3) @(posedge clk_sys);
        `CHK(fault_flags, 5'h00);
        u_host.bus_wr(4'h8, 32'h0000_0000);
        u_host.bus_wr(4'ha, 32'h0000_0032);
        motor_speed <= 16'hffcd;
        repeat (3) @(posedge clk_sys);
        `CHK(fault_flags, 5'h02);
        motor_speed <= 16'h0000;
        u_host.bus_wr(4'hc, 32'h0000_03e8);
        u_host.bus_wr(4'hd, 32'hffff_fc18);
        motor_position <= 32'hffff_fc17;
        repeat (3) @(posedge clk_sys);
        `CHK(fault_flags, 5'h08);
        motor_position <= 32'h0000_03e8;
        repeat (3) @(posedge clk_sys);
        `CHK(fault_flags, 5'h00);
        u_host.bus_wr(4'hb, 32'h0000_000a);
        speed_change <= 16'h000b;
        repeat (30) @(posedge clk_sys);
        `CHK(fault_flags[2], 1'b0);
        repeat (40) @(posedge clk_sys);
        `CHK(fault_flags[2], 1'b1);
        speed_change <= 16'h0000;
        u_host.bus_wr(4'he, 32'h0000_0002);
        profile_stream_empty <= 1'b1;
        repeat (30) @(posedge clk_sys);
        `CHK(fault_flags, 5'h00);
        repeat (100) @(posedge clk_sys);
        `CHK(fault_flags, 5'h10);
        profile_stream_empty <= 1'b0;
        repeat (50) @(posedge clk_sys);
        `CHK(motor_stop, 1'b0);
        for (int t = 0; t < 16; t++) begin
            u_host.bus_wr(4'h1, 32'(t));
            u_host.bus_rd(4'h4, d);
            `CHK(d[1:0], mode_query_cmd(t));
        end
        u_host.bus_wr(4'h1, 32'h0000_0001);
        u_host.bus_wr(4'h4, 32'h0000_0000);
        u_host.bus_rd(4'h4, d);
        `CHK(d[1:0], 2'h0);
        u_host.bus_wr(4'h0, 32'h0b05_1f00);
        u_host.bus_wr(4'h1, 32'h0000_0003);
        motion_active <= 1'b1;
        tk(2);
        u_host.bus_rd(4'h4, d);
        `CHK(d[1:0], 2'h3);
        motion_active <= 1'b0;
        tk(2);
        u_host.bus_rd(4'h4, d);
        `CHK(d[1:0], 2'h0);
        u_host.bus_wr(4'h3, 32'h005a_0800);
        u_host.bus_wr(4'h1, 32'h0000_0009);
        tk(2);
        u_host.bus_rd(4'h4, d);
        `CHK(d[1:0], 2'h1);
        tk(4);
        u_host.bus_rd(4'h4, d);
        `CHK(d[1:0], 2'h2);
        u_host.bus_wr(4'h3, 32'h0000_0001);
        u_host.bus_wr(4'h1, 32'h0000_0004);
        dig_inputs <= 8'h01;
        tk(1);
        `CHK(rec_mode, 2'h0);
        u_host.bus_wr(4'h1, 32'h0000_0005);
        tk(1);
        `CHK(rec_mode, 2'h0);
        u_host.bus_wr(4'h1, 32'h0000_0007);
        drive_outputs <= 8'h01;
        tk(1);
        `CHK(rec_mode, 2'h2);
        u_host.bus_wr(4'h2, 32'h0000_0002);
        u_host.bus_wr(4'h1, 32'h0000_0002);
        n0 = n;
        tk(1020);
        `CHK(rec_mode, 2'h2);
        tk(10);
        `CHK(rec_mode, 2'h0);
        u_host.bus_wr(4'h5, 32'h0000_0000);
        for (int k = 0; k < 4; k++) begin
            u_host.bus_rd(4'h6, d);
            `CHK(d, sv(5'h00, 8'(n0 + 2*k)));
        end
        u_host.bus_wr(4'h5, 32'h0000_03fe);
        for (int k = 510; k < 512; k++) begin
            e = sv(5'h1f, 8'(n0 + 2*k));
            u_host.bus_rd(4'h6, d);
            `CHK(d, {{16{e[15]}}, e[15:0]});
        end
        u_host.bus_wr(4'h5, 32'h0000_0400);
        u_host.bus_rd(4'h6, d);
        `CHK(d, 32'h0000_0000);
        tally_and_finish();
    end
endmodule // str_recorder_bench
`default_nettype wire
